// *** core/timer_chan.sv ***
// One interval counter: count register, programming, latching and status byte.
// Assumes a control word write is presented to every channel at once.
`timescale 1ns/1ns
module timer_chan #(
   parameter logic [1:0] CHAN = 2'h0
) (
   input wire logic ref_clk,
   input wire logic rstn,
   tmr_io_if.chan io
);
   typedef struct packed {
      logic [15:0] holdCnt;
      logic [15:0] count;
      logic [15:0] latchCnt;
      logic cntLatched;
      logic [7:0] statLatch;
      logic statLatched;
      logic nullCnt;
      logic [5:0] prog;
      timer_pkg::byte_phase_t wrPhase;
      timer_pkg::byte_phase_t rdPhase;
      logic [7:0] rdata;
   } chan_t;

   chan_t s_q;
   chan_t s_d;
   logic [1:0] rwSel;
   logic [7:0] statNow;
   logic [15:0] rdSrc;
   logic cwSel;
   logic cwRb;

   assign rwSel = s_q.prog[timer_pkg::RW_HI:timer_pkg::RW_LO];
   // Status: out level, null count, access, mode and BCD bits.
   assign statNow = {s_q.count[15], s_q.nullCnt, s_q.prog}; // RL2 RL3 RL4 RL5 RL6
   assign rdSrc = s_q.cntLatched ? s_q.latchCnt : s_q.count; // RL8
   assign cwRb = io.wdata[timer_pkg::SEL_HI:timer_pkg::SEL_LO] == timer_pkg::SEL_READBACK;
   assign cwSel = io.wdata[timer_pkg::SEL_HI:timer_pkg::SEL_LO] == CHAN;

   // Next-state logic for programming, loading, latching and port reads.
   always_comb begin
      s_d = s_q;
      if (!s_q.nullCnt) begin
         s_d.count = s_q.count - 16'h0001;
      end else begin
         s_d.count = s_q.holdCnt; // RL3
         s_d.nullCnt = 1'b0;
      end
      if (io.wrCtrl) begin
         if (cwRb) begin // RL15
            if (io.wdata[timer_pkg::MODE_LO + CHAN]) begin
               if (!io.wdata[timer_pkg::RB_NCNT] && !s_q.cntLatched) begin // RL16
                  s_d.latchCnt = s_q.count;
                  s_d.cntLatched = 1'b1;
               end
               if (!io.wdata[timer_pkg::RB_NSTAT] && !s_q.statLatched) begin // RL1 RL16
                  s_d.statLatch = statNow;
                  s_d.statLatched = 1'b1;
               end
            end
         end else if (cwSel) begin
            if (io.wdata[timer_pkg::RW_HI:timer_pkg::RW_LO] == timer_pkg::RW_LATCH) begin
               if (!s_q.cntLatched) begin // RL16
                  s_d.latchCnt = s_q.count;
                  s_d.cntLatched = 1'b1;
               end
            end else begin
               s_d.prog = io.wdata[timer_pkg::RW_HI:timer_pkg::BCD_BIT];
               s_d.wrPhase = timer_pkg::BYTE_LOW;
               s_d.rdPhase = timer_pkg::BYTE_LOW;
               s_d.cntLatched = 1'b0;
               s_d.statLatched = 1'b0;
            end
         end
      end
      if (io.wrPort) begin // RL7
         case (rwSel)
            timer_pkg::RW_LSB: begin
               s_d.holdCnt = {8'h00, io.wdata};
               s_d.nullCnt = 1'b1;
            end
            timer_pkg::RW_MSB: begin
               s_d.holdCnt = {io.wdata, 8'h00};
               s_d.nullCnt = 1'b1;
            end
            timer_pkg::RW_BOTH: begin
               if (s_q.wrPhase == timer_pkg::BYTE_LOW) begin
                  s_d.holdCnt[7:0] = io.wdata;
                  s_d.wrPhase = timer_pkg::BYTE_HIGH;
               end else begin
                  s_d.holdCnt[15:8] = io.wdata;
                  s_d.wrPhase = timer_pkg::BYTE_LOW;
                  s_d.nullCnt = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (io.rdPort) begin
         if (s_q.statLatched) begin // RL1
            s_d.rdata = s_q.statLatch;
            s_d.statLatched = 1'b0;
         end else begin // RL8
            case (rwSel)
               timer_pkg::RW_LSB: begin
                  s_d.rdata = rdSrc[7:0];
                  s_d.cntLatched = 1'b0;
               end
               timer_pkg::RW_MSB: begin
                  s_d.rdata = rdSrc[15:8];
                  s_d.cntLatched = 1'b0;
               end
               default: begin
                  if (s_q.rdPhase == timer_pkg::BYTE_LOW) begin
                     s_d.rdata = rdSrc[7:0];
                     s_d.rdPhase = timer_pkg::BYTE_HIGH;
                  end else begin
                     s_d.rdata = rdSrc[15:8];
                     s_d.rdPhase = timer_pkg::BYTE_LOW;
                     s_d.cntLatched = 1'b0;
                  end
               end
            endcase
         end
      end
      if (!rstn) begin
         s_d = '0;
         s_d.count = timer_pkg::CNT_RESET;
         s_d.prog = timer_pkg::PROG_RESET;
      end
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   assign io.rdata = s_q.rdata;
   assign io.outLevel = s_q.count[15]; // RL2
endmodule : timer_chan

// *** core/timer_pkg.sv ***
// Constants, field positions and state types for the interval timer access ports
// and the standalone countdown timer.
// Assumes an I/O request port decoded from host I/O cycles in the ref_clk domain.
//
// Summary of operation
// [RL1] After read-back with status latch, next port read returns the status byte.
// [RL2] Status bit 7 shows the counter output level.
// [RL3] Status bit 6 is 1 while a written count awaits transfer to the counter.
// [RL4] Status bits 5:4 echo the programmed byte access selection.
// [RL5] Status bits 3:1 echo the programmed counter mode.
// [RL6] Status bit 0 is 0 for binary, 1 for BCD counting.
// [RL7] Byte port loads the 16-bit count in the programmed byte order.
// [RL8] Port read returns the current or latched count.
// [RL9] Any 16- or 32-bit write loads the countdown timer; upper half ignored.
// [RL10] Countdown timer decrements to zero and holds there until rewritten.
// [RL11] Countdown bits 15:0 write count, read count; bits 31:16 read zero.
// [RL12] Software writes all sixteen countdown bits in one access.
// [RL13] Decode enable claims countdown accesses; disabled, they pass to the expansion bus.
// [RL14] Disabled decode does not stop the countdown.
// [RL15] Control write with bits 7:6 set is read-back: 3:1 counters, 5:4 latch selects.
// [RL16] A second latch before the first is read is ignored.
// [RL17] Countdown decrements once per timebase tick of a parameter rate.
package timer_pkg;

   // ****************************************************************
   // Addresses
   // ****************************************************************
   localparam logic [15:0] CNT0_ADDR = 16'h0040;
   localparam logic [15:0] CTRL_ADDR = 16'h0043;
   localparam logic [15:0] BIOS_TMR_ADDR = 16'h0078;

   // ****************************************************************
   // Control word fields
   // ****************************************************************
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam int RW_HI = 5;
   localparam int RW_LO = 4;
   localparam int MODE_HI = 3;
   localparam int MODE_LO = 1;
   localparam int BCD_BIT = 0;
   localparam int RB_NCNT = 5;
   localparam int RB_NSTAT = 4;
   localparam logic [1:0] SEL_READBACK = 2'h3;
   localparam logic [1:0] RW_LATCH = 2'h0;
   localparam logic [1:0] RW_LSB = 2'h1;
   localparam logic [1:0] RW_MSB = 2'h2;
   localparam logic [1:0] RW_BOTH = 2'h3;

   // ****************************************************************
   // Status byte fields and reset values
   // ****************************************************************
   localparam int ST_OUT = 7;
   localparam int ST_NULL = 6;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [5:0] PROG_RESET = 6'h00;

   // ****************************************************************
   // Countdown timebase
   // ****************************************************************
   localparam int CLK_MHZ = 250;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;

   typedef enum logic [0:0] {
      BYTE_LOW = 1'b0,
      BYTE_HIGH = 1'b1
   } byte_phase_t;

endpackage : timer_pkg

// *** core/tmr_io_if.sv ***
// Carrier for the per-counter byte port between the top and each channel.
// Assumes all signals belong to the ref_clk domain.
`timescale 1ns/1ns
interface tmr_io_if;
   logic wrPort;
   logic rdPort;
   logic wrCtrl;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic outLevel;
   modport top (output wrPort, output rdPort, output wrCtrl, output wdata,
                input rdata, input outLevel);
   modport chan (input wrPort, input rdPort, input wrCtrl, input wdata,
                 output rdata, output outLevel);
endinterface : tmr_io_if

// *** core/timer_readback_and_bios_countdown_timer.sv ***
// Top of the interval timer access ports and the standalone countdown timer.
// Assumes one-cycle I/O requests decoded from host I/O cycles, synchronous to ref_clk.
`timescale 1ns/1ns
module timer_readback_and_bios_countdown_timer #(
   parameter int TICK_CYCLES = timer_pkg::TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic ioWr,
   input wire logic ioRd,
   input wire logic [15:0] ioAddr,
   input wire logic [3:0] ioByteEn,
   input wire logic [31:0] ioWdata,
   input wire logic biosDecodeEn,
   output logic [31:0] ioRdata,
   output logic ioRdValid,
   output logic biosClaim,
   output logic [2:0] counterOut
);
   typedef struct packed {
      logic [15:0] biosCnt;
      logic [15:0] tickCnt;
      logic [31:0] rdata;
      logic rdValid;
      logic [1:0] rdSel;
      logic rdChan;
   } top_t;

   top_t s_q;
   top_t s_d;
   logic biosHit;
   logic tick;
   logic ctrlWr;
   logic [7:0] chanRdata [3];

   // ****************************************************************
   // Interval counter channels
   // ****************************************************************
   assign ctrlWr = ioWr && ioAddr == timer_pkg::CTRL_ADDR;
   for (genvar i = 0; i < 3; i++) begin : g_chan
      tmr_io_if io ();
      assign io.wrPort = ioWr && ioAddr == timer_pkg::CNT0_ADDR + 16'(i);
      assign io.rdPort = ioRd && ioAddr == timer_pkg::CNT0_ADDR + 16'(i);
      assign io.wrCtrl = ctrlWr; // RL15
      assign io.wdata = ioWdata[7:0];
      assign chanRdata[i] = io.rdata;
      assign counterOut[i] = io.outLevel;
      timer_chan #(.CHAN(2'(i))) u_chan (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .io(io)
      );
   end

   // ****************************************************************
   // Countdown timer
   // ****************************************************************
   assign biosHit = biosDecodeEn && ioAddr == timer_pkg::BIOS_TMR_ADDR; // RL13
   assign biosClaim = biosHit && (ioWr || ioRd); // RL13
   assign tick = s_q.tickCnt == 16'(TICK_CYCLES - 1); // RL17

   // Next state: timebase, countdown and read return.
   always_comb begin
      s_d = s_q;
      s_d.tickCnt = tick ? 16'h0000 : s_q.tickCnt + 16'h0001;
      if (tick && s_q.biosCnt != 16'h0000) begin // RL10 RL14
         s_d.biosCnt = s_q.biosCnt - 16'h0001;
      end
      if (ioWr && biosHit && ioByteEn[1:0] == 2'h3) begin // RL9 RL12
         s_d.biosCnt = ioWdata[15:0];
      end
      s_d.rdValid = ioRd && (biosHit || ioAddr[15:2] == timer_pkg::CNT0_ADDR[15:2]);
      s_d.rdChan = ioRd && !biosHit;
      s_d.rdSel = ioAddr[1:0];
      s_d.rdata = ioRd && biosHit ? {16'h0000, s_q.biosCnt} : 32'h0000_0000; // RL11
      if (!rstn) begin
         s_d = '0;
      end
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // Channel reads land one cycle after the request, as does the countdown read.
   always_comb begin
      ioRdata = s_q.rdata;
      if (s_q.rdChan && s_q.rdSel != 2'h3) begin
         ioRdata = {24'h00_0000, chanRdata[s_q.rdSel]};
      end
   end
   assign ioRdValid = s_q.rdValid;
endmodule : timer_readback_and_bios_countdown_timer

// *** bench/timer_host_model.sv ***
// Host model that issues one-cycle I/O reads and writes to the timer block.
// Assumes the block answers a read one clock after the request is taken.
`timescale 1ns/1ns
module timer_host_model (
   input wire logic ref_clk,
   output logic ioWr = 1'b0,
   output logic ioRd = 1'b0,
   output logic [15:0] ioAddr = 16'h0000,
   output logic [3:0] ioByteEn = 4'h0,
   output logic [31:0] ioWdata = 32'h0000_0000,
   input wire logic [31:0] ioRdata,
   input wire logic ioRdValid,
   input wire logic biosClaim
);
   // Drives one request for one cycle, then parks the bus on inverted values.
   task automatic req(input logic wr, input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] q, output logic v, output logic c);
      @(posedge ref_clk);
      ioWr <= wr;
      ioRd <= !wr;
      ioAddr <= a;
      ioByteEn <= be;
      ioWdata <= d;
      @(posedge ref_clk);
      c = biosClaim;
      ioWr <= 1'b0;
      ioRd <= 1'b0;
      ioAddr <= ~a;
      ioByteEn <= ~be;
      ioWdata <= ~d;
      @(posedge ref_clk);
      v = ioRdValid;
      q = ioRdata;
   endtask : req
endmodule : timer_host_model

// *** bench/timer_readback_and_bios_countdown_timer_properties.sv ***
// Port-level properties of the timer block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module timer_readback_and_bios_countdown_timer_properties (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic ioWr,
   input wire logic ioRd,
   input wire logic [15:0] ioAddr,
   input wire logic [3:0] ioByteEn,
   input wire logic [31:0] ioWdata,
   input wire logic biosDecodeEn,
   input wire logic [31:0] ioRdata,
   input wire logic ioRdValid,
   input wire logic biosClaim,
   input wire logic [2:0] counterOut
);
   // All properties run on the one clock and sleep in reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_read_answered: assert property (
      ioRd && ioAddr[15:2] == 14'h0010 |=> ioRdValid) else $error("Port read not answered.");
   a_valid_has_cause: assert property (
      ioRdValid |-> $past(ioRd)) else $error("Read data without a read.");
   a_claim_follows_enable: assert property (
      (ioWr || ioRd) && ioAddr == 16'h0078 |-> biosClaim == biosDecodeEn)
      else $error("Claim does not follow decode enable.");
   a_claim_needs_access: assert property (
      biosClaim |-> (ioWr || ioRd) && ioAddr == 16'h0078) else $error("Stray claim.");
   a_unclaimed_silent: assert property (
      ioRd && ioAddr == 16'h0078 && !biosDecodeEn |=> !ioRdValid)
      else $error("Disabled timer answered.");
   a_claimed_read: assert property (
      ioRd && ioAddr == 16'h0078 && biosDecodeEn |=> ioRdValid) else $error("Timer read lost.");
   a_upper_half_zero: assert property (
      ioRd && ioAddr == 16'h0078 && biosDecodeEn |=> ioRdata[31:16] == 16'h0000)
      else $error("Upper timer half not zero.");
   a_unmapped_silent: assert property (
      ioRd && ioAddr[15:2] != 14'h0010 && ioAddr != 16'h0078 |=> !ioRdValid)
      else $error("Unmapped read answered.");
endmodule : timer_readback_and_bios_countdown_timer_properties
bind timer_readback_and_bios_countdown_timer timer_readback_and_bios_countdown_timer_properties chk (
   .ref_clk(ref_clk), .rstn(rstn), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr),
   .ioByteEn(ioByteEn), .ioWdata(ioWdata), .biosDecodeEn(biosDecodeEn), .ioRdata(ioRdata),
   .ioRdValid(ioRdValid), .biosClaim(biosClaim), .counterOut(counterOut));

// *** bench/timer_readback_and_bios_countdown_timer_test.sv ***
// Self-checking bench for the timer access ports and countdown timer.
// Assumes the host model and the bound property checker.
`timescale 1ns/1ns
module timer_readback_and_bios_countdown_timer_test;
   localparam int TICKS = 2;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic biosDecodeEn = 1'b1;
   logic ioWr;
   logic ioRd;
   logic [15:0] ioAddr;
   logic [3:0] ioByteEn;
   logic [31:0] ioWdata;
   logic [31:0] ioRdata;
   logic ioRdValid;
   logic biosClaim;
   logic [2:0] counterOut;
   logic [31:0] q;
   logic v;
   logic c;
   logic [15:0] v1;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int t1;
   // Clock and cycle stamp.
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   timer_readback_and_bios_countdown_timer #(.TICK_CYCLES(TICKS)) uut (.ref_clk(ref_clk), .rstn(rstn),
      .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWdata(ioWdata),
      .biosDecodeEn(biosDecodeEn), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
      .biosClaim(biosClaim), .counterOut(counterOut));
   timer_host_model host (.ref_clk(ref_clk), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr),
      .ioByteEn(ioByteEn), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
      .biosClaim(biosClaim));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
      host.req(1'b1, a, d, be, q, v, c);
   endtask : wr
   task automatic rd(input logic [15:0] a);
      host.req(1'b0, a, 32'h0000_0000, 4'hF, q, v, c);
   endtask : rd
   task automatic tally_and_finish();
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Status bytes of all three counters, before and after the count transfer.
   task automatic t_status();
      wr(16'h0043, 32'h0000_0034, 4'h1);
      wr(16'h0040, 32'h0000_0000, 4'h1);
      wr(16'h0040, 32'h0000_0010, 4'h1);
      wr(16'h0043, 32'h0000_00E2, 4'h1);
      rd(16'h0040);
      chk({v, q[7:0]}, 32'h0000_0134);
      wr(16'h0043, 32'h0000_007B, 4'h1);
      wr(16'h0041, 32'h0000_0000, 4'h1);
      wr(16'h0043, 32'h0000_00E4, 4'h1);
      rd(16'h0041);
      chk({v, q[7:0]}, 32'h0000_01BB);
      wr(16'h0041, 32'h0000_0040, 4'h1);
      wr(16'h0043, 32'h0000_00E4, 4'h1);
      rd(16'h0041);
      chk({v, q[7:0]}, 32'h0000_013B);
      wr(16'h0043, 32'h0000_00A0, 4'h1);
      wr(16'h0042, 32'h0000_00F0, 4'h1);
      wr(16'h0043, 32'h0000_00E8, 4'h1);
      rd(16'h0042);
      chk({v, q[7:0]}, 32'h0000_01A0);
      chk({31'h0000_0000, counterOut[2]}, 32'h0000_0001);
      wr(16'h0043, 32'h0000_0090, 4'h1);
      wr(16'h0042, 32'h0000_00FF, 4'h1);
      wr(16'h0043, 32'h0000_00E8, 4'h1);
      rd(16'h0042);
      chk({v, q[7:0]}, 32'h0000_0110);
      rd(16'h0042);
      chk({v, q[7:0]}, 32'h0000_01F8);
   endtask : t_status
   // Second latch before the read is ignored; latched counts are exact.
   task automatic t_latch();
      wr(16'h0043, 32'h0000_0000, 4'h1);
      t1 = cyc;
      repeat (5) @(posedge ref_clk);
      wr(16'h0043, 32'h0000_0000, 4'h1);
      rd(16'h0040);
      v1[7:0] = q[7:0];
      rd(16'h0040);
      v1[15:8] = q[7:0];
      chk({24'h00_0000, v1[15:8]}, 32'h0000_000F);
      wr(16'h0043, 32'h0000_0000, 4'h1);
      t1 = cyc - t1;
      rd(16'h0040);
      v1 = v1 - {8'h00, q[7:0]};
      rd(16'h0040);
      v1 = v1 - {q[7:0], 8'h00};
      chk({16'h0000, v1}, 32'(t1));
   endtask : t_latch
   // Countdown load, rate, hold at zero, decode disable and refusals.
   task automatic t_countdown();
      wr(16'h0078, 32'hFFFF_0180, 4'hF);
      chk({31'h0000_0000, c}, 32'h0000_0001);
      rd(16'h0078);
      t1 = cyc;
      v1 = q[15:0];
      chk({16'h0000, q[31:24], v1[15:8]}, 32'h0000_0001);
      repeat (19) @(posedge ref_clk);
      rd(16'h0078);
      chk(32'(v1 - q[15:0]), 32'((cyc - t1) / TICKS));
      wr(16'h0078, 32'h0000_0008, 4'h3);
      biosDecodeEn <= 1'b0;
      rd(16'h0078);
      chk({30'h0000_0000, v, c}, 32'h0000_0000);
      repeat (30) @(posedge ref_clk);
      biosDecodeEn <= 1'b1;
      wr(16'h0078, 32'h0000_0040, 4'h1);
      rd(16'h0078);
      chk(q, 32'h0000_0000);
      rd(16'h0050);
      chk({31'h0000_0000, v}, 32'h0000_0000);
   endtask : t_countdown
   // Main sequence after reset.
   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      t_status();
      t_latch();
      t_countdown();
      tally_and_finish();
   end
   // Watchdog against a hang.
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      tally_and_finish();
   end
endmodule : timer_readback_and_bios_countdown_timer_test
